// [shared/tpse_pkg.sv]
package tpse_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_IEN = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_IOC = 8'h10;
    localparam logic [7:0] OFS_CNT = 8'h14;
    localparam logic [7:0] OFS_STEP = 8'h18;
    localparam logic [7:0] OFS_NOVL = 8'h1c;
    localparam logic [7:0] OFS_PDATA = 8'h20;
    localparam logic [7:0] OFS_PDIR = 8'h24;
    localparam logic [7:0] OFS_SEQ = 8'h28;
    localparam logic [7:0] OFS_ACC = 8'h2c;
    localparam logic [7:0] OFS_CON = 8'h30;
    localparam logic [7:0] OFS_DEC = 8'h34;
    localparam logic [7:0] OFS_HOLD = 8'h38;
    localparam logic [7:0] OFS_TBL = 8'h3c;
    // Field positions
    localparam int MODE_START_BIT = 7;
    localparam int CTRL_CCLR_BIT = 7;
    localparam int CTRL_CKS_LSB = 4;
    localparam int IEN_A_BIT = 0;
    localparam int IEN_B_BIT = 1;
    localparam int SEQ_EN_BIT = 0;
    localparam int TBL_IDX_LSB = 16;
    // Widths
    localparam int PSC_W = 13;
    localparam int CNT_W = 16;
    localparam int TBL_AW = 6;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_STEP = 16'hffff;
    localparam logic [15:0] RST_NOVL = 16'h1000;
    localparam logic [7:0] RST_PDATA = 8'h08;
    localparam logic [15:0] RST_COUNT = 16'h0010;
    // Tick source codes
    localparam logic [2:0] CKS_SYS = 3'h0;
    localparam logic [2:0] CKS_DIV2 = 3'h1;
    localparam logic [2:0] CKS_DIV4 = 3'h2;
    localparam logic [2:0] CKS_DIV8 = 3'h3;
    // Two-phase pairs in forward order: bit3 A, bit2 B, bit1 ~A, bit0 ~B
    localparam logic [3:0] PAIR_0 = 4'h9;
    localparam logic [3:0] PAIR_1 = 4'hc;
    localparam logic [3:0] PAIR_2 = 4'h6;
    localparam logic [3:0] PAIR_3 = 4'h3;
    typedef enum logic [2:0] {S_IDLE, S_ACCEL, S_CONST, S_DECEL, S_HOLD} tpse_state_t;
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } tpse_av_req_t;
endpackage

// [hw/tpse_slue_mem.sv]
`timescale 1ns/1ps
module tpse_slue_mem #(
    parameter int AW = 6,
    parameter int DW = 16
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Registered read keeps the period lookup off the compare path
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// [hw/tpse_core.sv]
`timescale 1ns/1ps
module tpse_core #(
    parameter int TBL_AW_P = 6
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire tpse_pkg::tpse_av_req_t av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    input wire logic ext_tick_in,
    output logic phase_a_out,
    output logic phase_b_out,
    output logic phase_a_bar_out,
    output logic phase_b_bar_out,
    output logic [3:0] phase_oe,
    output logic irq
);
    import tpse_pkg::*;

    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] mode_q;
    logic [7:0] ctrl_q;
    logic [7:0] ien_q;
    logic [7:0] ioc_q;
    logic [7:0] pdr_q;
    logic [7:0] pdir_q;
    logic [7:0] seq_q;
    logic [1:0] flag_q;
    logic [PSC_W-1:0] psc_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] step_q;
    logic [CNT_W-1:0] novl_q;
    logic [15:0] acc_q;
    logic [15:0] con_q;
    logic [15:0] dec_q;
    logic [15:0] hold_q;
    logic [15:0] steps_q;
    logic [TBL_AW_P-1:0] sidx_q;
    logic [1:0] pidx_q;
    logic dir_q;
    logic ext_q;
    logic irq_q;
    logic [3:0] phase_q;
    tpse_state_t state_q;
    logic [15:0] tbl_rdata;

    // Pair table lookup, shared by current and next pattern
    function automatic logic [3:0] pair_of(input logic [1:0] i);
        case (i)
            2'd0: pair_of = PAIR_0;
            2'd1: pair_of = PAIR_1;
            2'd2: pair_of = PAIR_2;
            default: pair_of = PAIR_3;
        endcase
    endfunction

    // Tick source select from prescaler taps, or the external tick edge for codes above CKS_DIV8
    function automatic logic sel_tick(input logic [2:0] c, input logic [PSC_W-1:0] p,
                                      input logic e);
        case (c)
            CKS_SYS: sel_tick = 1'b1;
            CKS_DIV2: sel_tick = p[0];
            CKS_DIV4: sel_tick = &p[1:0];
            CKS_DIV8: sel_tick = &p[2:0];
            default: sel_tick = e;
        endcase
    endfunction

    // Bus strobes: a write lands on the edge where waitrequest is seen low
    wire wr_go = av_req.write & ~av_req.read & ~wait_q;
    wire rd_cap = av_req.read & wait_q;
    wire [7:0] adr = av_req.address;
    wire [31:0] wd = av_req.writedata;
    wire w_mode = wr_go & (adr == OFS_MODE);
    wire w_ctrl = wr_go & (adr == OFS_CTRL);
    wire w_ien = wr_go & (adr == OFS_IEN);
    wire w_stat = wr_go & (adr == OFS_STAT);
    wire w_ioc = wr_go & (adr == OFS_IOC);
    wire w_cnt = wr_go & (adr == OFS_CNT);
    wire w_step = wr_go & (adr == OFS_STEP);
    wire w_novl = wr_go & (adr == OFS_NOVL);
    wire w_pdr = wr_go & (adr == OFS_PDATA);
    wire w_pdir = wr_go & (adr == OFS_PDIR);
    wire w_seq = wr_go & (adr == OFS_SEQ);
    wire w_acc = wr_go & (adr == OFS_ACC);
    wire w_con = wr_go & (adr == OFS_CON);
    wire w_dec = wr_go & (adr == OFS_DEC);
    wire w_hold = wr_go & (adr == OFS_HOLD);
    wire w_tbl = wr_go & (adr == OFS_TBL);

    // Timer tick and compare events
    wire ext_rise = ext_tick_in & ~ext_q;
    wire tick = sel_tick(ctrl_q[CTRL_CKS_LSB +: 3], psc_q, ext_rise);
    wire cnt_en = mode_q[MODE_START_BIT] & tick;
    wire hit_a = cnt_en & (cnt_q == step_q);
    wire hit_b = cnt_en & (cnt_q == novl_q);
    wire cclr = ctrl_q[CTRL_CCLR_BIT];
    wire [CNT_W-1:0] cnt_d = w_cnt ? wd[CNT_W-1:0] :
                             (hit_a & cclr) ? '0 :
                             cnt_en ? cnt_q + 16'h0001 : cnt_q;

    // Flags: hardware set wins over a software clear in the same cycle
    wire [1:0] flag_clr = w_stat ? ~wd[1:0] : 2'b00;
    wire [1:0] flag_d = (flag_q & ~flag_clr) | {hit_b, hit_a};

    // Sequencer decode
    wire seq_en = seq_q[SEQ_EN_BIT];
    wire moving = seq_en & ((state_q == S_ACCEL) | (state_q == S_CONST) |
                            (state_q == S_DECEL));
    wire [1:0] pidx_nx = dir_q ? pidx_q - 2'd1 : pidx_q + 2'd1;
    wire [3:0] pair_cur = pair_of(pidx_q);
    wire [3:0] pair_nx = pair_of(pidx_nx);
    wire [3:0] single = pair_cur & pair_nx;
    wire [15:0] steps_inc = steps_q + 16'h0001;
    wire [15:0] lim = (state_q == S_ACCEL) ? acc_q :
                      (state_q == S_CONST) ? con_q :
                      (state_q == S_DECEL) ? dec_q : hold_q;
    wire last = hit_a & (steps_inc >= lim);
    wire seq_b = moving & hit_b;
    wire seq_a = moving & hit_a;

    // Phase data: sequencer updates override software in the same cycle
    wire [7:0] pdr_d = seq_b ? {pdr_q[7:4], single} :
                       seq_a ? {pdr_q[7:4], pair_nx} :
                       (seq_en & (state_q == S_IDLE)) ? {pdr_q[7:4], pair_cur} :
                       w_pdr ? wd[7:0] : pdr_q;

    // Step period: table drives it while ramping
    wire ramp = hit_a & seq_en & ((state_q == S_ACCEL) | (state_q == S_DECEL));
    wire [CNT_W-1:0] step_d = ramp ? tbl_rdata :
                              w_step ? wd[CNT_W-1:0] : step_q;

    // Read mux, unmapped offsets read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (adr)
            OFS_MODE: rdata_d[7:0] = mode_q;
            OFS_CTRL: rdata_d[7:0] = ctrl_q;
            OFS_IEN: rdata_d[7:0] = ien_q;
            OFS_STAT: rdata_d[1:0] = flag_q;
            OFS_IOC: rdata_d[7:0] = ioc_q;
            OFS_CNT: rdata_d[15:0] = cnt_q;
            OFS_STEP: rdata_d[15:0] = step_q;
            OFS_NOVL: rdata_d[15:0] = novl_q;
            OFS_PDATA: rdata_d[7:0] = pdr_q;
            OFS_SEQ: rdata_d = {steps_q, 5'h00, state_q, dir_q, pidx_q, 4'h0, seq_en};
            OFS_ACC: rdata_d[15:0] = acc_q;
            OFS_CON: rdata_d[15:0] = con_q;
            OFS_DEC: rdata_d[15:0] = dec_q;
            OFS_HOLD: rdata_d[15:0] = hold_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Bus handshake: one wait cycle, then one ready cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~((av_req.read | av_req.write) & wait_q);
            if (rd_cap) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Software-only registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode_q <= RST_BYTE;
            ctrl_q <= RST_BYTE;
            ien_q <= RST_BYTE;
            ioc_q <= RST_BYTE;
            pdir_q <= RST_BYTE;
            seq_q <= RST_BYTE;
            novl_q <= RST_NOVL;
            acc_q <= RST_COUNT;
            con_q <= RST_COUNT;
            dec_q <= RST_COUNT;
            hold_q <= RST_COUNT;
        end else begin
            if (w_mode) mode_q <= wd[7:0];
            if (w_ctrl) ctrl_q <= wd[7:0];
            if (w_ien) ien_q <= wd[7:0];
            if (w_ioc) ioc_q <= wd[7:0];
            if (w_pdir) pdir_q <= wd[7:0];
            if (w_seq) seq_q <= wd[7:0];
            if (w_novl) novl_q <= wd[CNT_W-1:0];
            if (w_acc) acc_q <= wd[15:0];
            if (w_con) con_q <= wd[15:0];
            if (w_dec) dec_q <= wd[15:0];
            if (w_hold) hold_q <= wd[15:0];
        end
    end

    // Timer datapath
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            psc_q <= '0;
            cnt_q <= '0;
            step_q <= RST_STEP;
            flag_q <= 2'b00;
            ext_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            psc_q <= psc_q + 13'h0001;
            cnt_q <= cnt_d;
            step_q <= step_d;
            flag_q <= flag_d;
            ext_q <= ext_tick_in;
            irq_q <= (flag_q[0] & ien_q[IEN_A_BIT]) | (flag_q[1] & ien_q[IEN_B_BIT]);
        end
    end

    // Run profile: accelerate, constant, decelerate, hold, swap direction
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= S_IDLE;
            pdr_q <= RST_PDATA;
            steps_q <= 16'h0000;
            sidx_q <= '0;
            pidx_q <= 2'd0;
            dir_q <= 1'b0;
        end else begin
            pdr_q <= pdr_d;
            if (!seq_en) begin
                state_q <= S_IDLE;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        state_q <= S_ACCEL;
                        steps_q <= 16'h0000;
                        sidx_q <= '0;
                    end
                    S_ACCEL: if (hit_a) begin
                        pidx_q <= pidx_nx;
                        sidx_q <= sidx_q + 1'b1;
                        steps_q <= last ? 16'h0000 : steps_inc;
                        if (last) state_q <= S_CONST;
                    end
                    S_CONST: if (hit_a) begin
                        pidx_q <= pidx_nx;
                        steps_q <= last ? 16'h0000 : steps_inc;
                        if (last) begin
                            state_q <= S_DECEL;
                            sidx_q <= sidx_q - 1'b1;
                        end
                    end
                    S_DECEL: if (hit_a) begin
                        pidx_q <= pidx_nx;
                        if (sidx_q != '0) sidx_q <= sidx_q - 1'b1;
                        steps_q <= last ? 16'h0000 : steps_inc;
                        if (last) state_q <= S_HOLD;
                    end
                    S_HOLD: if (hit_a) begin
                        steps_q <= last ? 16'h0000 : steps_inc;
                        if (last) begin
                            state_q <= S_ACCEL;
                            dir_q <= ~dir_q;
                            sidx_q <= '0;
                        end
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // Period table, loaded by software, read by the ramp
    tpse_slue_mem #(
        .AW(TBL_AW_P),
        .DW(16)
    ) u_mem (
        .clk_sys(clk_sys),
        .wr_en(w_tbl),
        .wr_addr(wd[TBL_IDX_LSB +: TBL_AW_P]),
        .wr_data(wd[15:0]),
        .rd_addr(sidx_q),
        .rd_data(tbl_rdata)
    );

    // Pin drive per line; a line with direction 0 stays low
    for (genvar i = 0; i < 4; i++) begin : g_ph
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                phase_q[i] <= 1'b0;
            end else begin
                phase_q[i] <= pdr_q[i] & pdir_q[i];
            end
        end
    end

    assign phase_a_out = phase_q[3];
    assign phase_b_out = phase_q[2];
    assign phase_a_bar_out = phase_q[1];
    assign phase_b_bar_out = phase_q[0];
    assign phase_oe = pdir_q[3:0];
    assign irq = irq_q;
    assign av_readdata = rdata_q;
    assign av_waitrequest = wait_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_psc;
        1'b1 |=> psc_q == $past(psc_q) + 13'h0001;
    endproperty
    a_psc: assert property (p_psc) else $error("prescaler skipped");

    property p_stop;
        !mode_q[MODE_START_BIT] && !w_cnt |=> cnt_q == $past(cnt_q);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved stopped");

    property p_flag_a;
        hit_a |=> flag_q[0] ##1 (irq == ien_q[IEN_A_BIT] || irq);
    endproperty
    a_flag_a: assert property (p_flag_a) else $error("match A lost");

    property p_flag_b;
        hit_b |=> flag_q[1];
    endproperty
    a_flag_b: assert property (p_flag_b) else $error("match B lost");

    property p_clear;
        hit_a && cclr && !w_cnt |=> cnt_q == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("no clear on A");

    property p_keep;
        flag_q[0] && !w_stat && ien_q[IEN_A_BIT] && !w_ien |=> ##1 irq;
    endproperty
    a_keep: assert property (p_keep) else $error("irq dropped");

    property p_single;
        seq_b && !seq_a |=> $countones(pdr_q[3:0]) == 1;
    endproperty
    a_single: assert property (p_single) else $error("gap not single");

    property p_pair;
        seq_a && !seq_b |=> $countones(pdr_q[3:0]) == 2 && pdr_q[3:0] == $past(pair_nx);
    endproperty
    a_pair: assert property (p_pair) else $error("bad pair");

    property p_hold;
        seq_en && state_q == S_HOLD && !w_pdr && !w_seq |=> $stable(pdr_q);
    endproperty
    a_hold: assert property (p_hold) else $error("hold changed output");

    property p_swap;
        seq_en && state_q == S_HOLD && last |=> dir_q != $past(dir_q) && state_q == S_ACCEL;
    endproperty
    a_swap: assert property (p_swap) else $error("no direction swap");

    property p_pin;
        1'b1 |=> phase_a_out == ($past(pdr_q[3]) & $past(pdir_q[3]));
    endproperty
    a_pin: assert property (p_pin) else $error("pin A mismatch");
endmodule

// [dv/tpse_motor_model.sv]
`timescale 1ns/1ps
module tpse_motor_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] coils,
    output logic [15:0] pos_q,
    output logic fault_q
);
    // Half-step ring in forward order; any other jump loses a step or shorts a bridge
    localparam logic [3:0] RING[8] = '{4'h9, 4'h8, 4'hc, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1};
    logic [3:0] last_q;
    int oi;
    int ni;
    // Rotor follows each energised pattern by one half step
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pos_q <= 16'h0000;
            fault_q <= 1'b0;
            last_q <= 4'h0;
        end else if (coils !== last_q) begin
            oi = -1;
            ni = -1;
            for (int i = 0; i < 8; i++) begin
                if (RING[i] == last_q) oi = i;
                if (RING[i] == coils) ni = i;
            end
            if (coils[3] && coils[1] || coils[2] && coils[0]) fault_q <= 1'b1;
            if (oi >= 0 && ni == (oi + 1) % 8) pos_q <= pos_q + 16'h0001;
            else if (oi >= 0 && ni == (oi + 7) % 8) pos_q <= pos_q - 16'h0001;
            else if (oi >= 0) fault_q <= 1'b1;
            last_q <= coils;
        end
    end
endmodule

// [dv/two_phase_stepper_excitation_tb.sv]
`timescale 1ns/1ps
module two_phase_stepper_excitation_tb;
    import tpse_pkg::*;
    logic clk_sys;
    logic reset;
    logic ext_tick_in;
    logic irq;
    logic irq_last;
    tpse_av_req_t av_req;
    logic [31:0] av_readdata;
    logic [31:0] r;
    logic av_waitrequest;
    logic [3:0] ph;
    logic [3:0] ph_last;
    logic [3:0] phase_oe;
    logic [15:0] pos;
    logic fault;
    int fails;
    int compares;
    int nch;
    int n;
    int k;
    int nx;
    logic [31:0] rd_q[$];
    logic [3:0] ph_q[$];
    logic irq_q[$];
    longint tm[64];
    longint cyc;
    localparam logic [3:0] FW[4] = '{PAIR_0, PAIR_1, PAIR_2, PAIR_3};
    localparam logic [7:0] RA[8] = '{OFS_MODE, OFS_CTRL, OFS_IEN, OFS_CNT, OFS_STEP, OFS_NOVL,
        OFS_PDATA, 8'hfc};
    localparam logic [31:0] RV[8] = '{32'h0, 32'h0, 32'h0, 32'h0, {16'h0, RST_STEP},
        {16'h0, RST_NOVL}, {24'h0, RST_PDATA}, 32'h0};

    tpse_core DUT (.clk_sys(clk_sys), .reset(reset), .av_req(av_req),
        .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
        .ext_tick_in(ext_tick_in), .phase_a_out(ph[3]), .phase_b_out(ph[2]),
        .phase_a_bar_out(ph[1]), .phase_b_bar_out(ph[0]), .phase_oe(phase_oe), .irq(irq));
    tpse_motor_model MOTOR (.clk_sys(clk_sys), .reset(reset), .coils(ph), .pos_q(pos),
        .fault_q(fault));

    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task close_out();
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One bus access; held until waitrequest is seen low, then released for a cycle
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        av_req <= '{read: !wr, write: wr, address: a, writedata: d};
        @(posedge clk_sys);
        // No cycle count assumed; only the watchdog ends a stuck wait
        while (av_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        av_req <= '0;
        @(posedge clk_sys);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // External tick pulses, slow enough for the input edge detector
    task tick(input int t);
        repeat (t) begin
            ext_tick_in <= 1'b1;
            repeat (2) @(posedge clk_sys);
            ext_tick_in <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask

    // Watches read data, irq and coil changes against the oldest notes
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (!reset && av_req.read && av_waitrequest === 1'b0) begin
            check("read note", {31'h0, rd_q.size() != 0}, 32'h1);
            if (rd_q.size() != 0) check("read data", av_readdata, rd_q.pop_front());
        end
        if (!reset && irq !== irq_last) begin
            check("irq note", {31'h0, irq_q.size() != 0}, 32'h1);
            if (irq_q.size() != 0) check("irq", {31'h0, irq}, {31'h0, irq_q.pop_front()});
            irq_last = irq;
        end
        if (!reset && ph !== ph_last) begin
            tm[nch % 64] = cyc;
            nch++;
            check("phase note", {31'h0, ph_q.size() != 0}, 32'h1);
            if (ph_q.size() != 0) check("phase", {28'h0, ph}, {28'h0, ph_q.pop_front()});
            ph_last = ph;
        end
    end

    // Watchdog against a hung handshake or a stalled sequencer
    initial begin
        repeat (40000) @(posedge clk_sys);
        fails++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        ext_tick_in = 1'b0;
        av_req = '0;
        fails = 0;
        compares = 0;
        nch = 0;
        cyc = 0;
        ph_last = 4'h0;
        irq_last = 1'b0;
        void'($urandom(32'ha7a3c369));
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        // Reset values, then an unmapped hole that reads zero
        for (int i = 0; i < 8; i++) rd(RA[i], RV[i]);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CTRL, 32'(c) << 4);
            rd(OFS_CTRL, 32'(c) << 4);
        end
        r = $urandom;
        wr(OFS_STEP, {16'h0, r[15:0]});
        wr(OFS_NOVL, {16'h0, r[31:16]});
        rd(OFS_STEP, {16'h0, r[15:0]});
        rd(OFS_NOVL, {16'h0, r[31:16]});
        // Counter on external ticks; it must freeze once start is cleared
        wr(OFS_CTRL, 32'h40);
        wr(OFS_CNT, 32'h0);
        wr(OFS_STEP, 32'h3);
        wr(OFS_NOVL, 32'h1000);
        wr(OFS_IEN, 32'h1);
        n = 4 + int'($urandom_range(4, 0));
        irq_q.push_back(1'b1);
        wr(OFS_MODE, 32'h80);
        tick(n);
        wr(OFS_MODE, 32'h0);
        tick(3);
        rd(OFS_CNT, 32'(n));
        rd(OFS_STAT, 32'h1);
        irq_q.push_back(1'b0);
        wr(OFS_IEN, 32'h0);
        irq_q.push_back(1'b1);
        wr(OFS_IEN, 32'h1);
        irq_q.push_back(1'b0);
        wr(OFS_STAT, 32'h0);
        rd(OFS_STAT, 32'h0);
        // Match on the non-overlap compare alone
        wr(OFS_NOVL, 32'(n + 2));
        wr(OFS_IEN, 32'h2);
        irq_q.push_back(1'b1);
        wr(OFS_MODE, 32'h80);
        tick(3);
        wr(OFS_MODE, 32'h0);
        rd(OFS_STAT, 32'h2);
        irq_q.push_back(1'b0);
        wr(OFS_STAT, 32'h0);
        // Profile: three accel, two constant, three decel steps, two held
        wr(OFS_IEN, 32'h0);
        wr(OFS_CTRL, 32'h80);
        wr(OFS_CNT, 32'h0);
        wr(OFS_STEP, 32'd70);
        wr(OFS_NOVL, 32'd10);
        for (int i = 0; i < 3; i++) wr(OFS_TBL, {10'h0, 6'(i), 16'(60 - 15 * i)});
        wr(OFS_ACC, 32'h3);
        rd(OFS_ACC, 32'h3);
        wr(OFS_CON, 32'h2);
        wr(OFS_DEC, 32'h3);
        wr(OFS_HOLD, 32'h2);
        ph_q.push_back(RST_PDATA[3:0]);
        wr(OFS_PDIR, 32'hf);
        ph_q.push_back(FW[0]);
        k = 0;
        for (int s = 0; s < 24; s++) begin
            nx = (s / 8 == 1) ? (k + 3) % 4 : (k + 1) % 4;
            ph_q.push_back(FW[k] & FW[nx]);
            ph_q.push_back(FW[nx]);
            k = nx;
        end
        wr(OFS_MODE, 32'h80);
        wr(OFS_SEQ, 32'h1);
        n = 0;
        while (ph_q.size() != 0 && n < 20000) begin
            @(posedge clk_sys);
            n++;
        end
        wr(OFS_MODE, 32'h0);
        check("phase drain", ph_q.size(), 32'h0);
        // Third run ends in hold, forward, pair index back at zero, steps cleared
        rd(OFS_SEQ, 32'h0000_0401);
        check("oe", {28'h0, phase_oe}, 32'hf);
        check("accel", {31'h0, tm[5] - tm[3] > tm[7] - tm[5]}, 32'h1);
        check("const", 32'(tm[9] - tm[7]), 32'd31);
        check("const2", 32'(tm[11] - tm[9]), 32'd31);
        check("decel", {31'h0, tm[17] - tm[15] > 32'd31}, 32'h1);
        check("gap", 32'(tm[8] - tm[7]), 32'd11);
        check("hold", {31'h0, tm[18] - tm[17] > 60}, 32'h1);
        check("motor pos", {16'h0, pos}, 32'd15);
        check("motor fault", {31'h0, fault}, 32'h0);
        close_out();
    end
endmodule
